// ==== rtl/atbi_addr_tenure.v ====
/*
  address tenure logic: master start strobe, address and parity drive,
  release after acknowledge, and snoop sampling with parity check.
  assumes all bus inputs are asynchronous to sys_clk and are synchronised
  here; bus pins are resolved outside from the output enables.
*/
`include "atbi_defs.vh"

// Overview of operation
// - start strobe asserts with address and attributes already valid.
// - start with a data-moving type also requests the data bus.
// - start strobe asserts in the first busy cycle.
// - start strobe is exactly one cycle wide.
// - start strobe floats when busy negates.
// - 32-bit two-way address bus, driven as master, read when snooping.
// - burst read gives aligned critical double word; burst write gives the requested address unchanged.
// - address held constant throughout a burst.
// - address driven the cycle after an accepted qualified grant.
// - address floats two cycles after acknowledge.
// - snoop address sampled only in the other master's start cycle.
// - parity drives, changes, floats and samples exactly like the address.
// - with checking enabled, even snooped parity raises a machine check event, or a checkstop event when machine check is disabled.
// - grant qualified only if busy and retry negated after acknowledge.
// - busy asserts the cycle after an accepted qualified grant.
module atbi_addr_tenure #(
  parameter ADDR_W = `ATBI_ADDR_W,
  parameter TT_W   = `ATBI_TT_W
) (
  input  wire              sys_clk,
  input  wire              arst_n,
  input  wire              req_valid,
  output wire              req_ready,
  input  wire [ADDR_W-1:0] req_addr,
  input  wire [TT_W-1:0]   req_type,
  input  wire              req_burst,
  input  wire              req_write,
  input  wire              parity_check_en,
  input  wire              mach_check_en,
  input  wire              bus_grant_n,
  input  wire              addr_acknowledge_n,
  input  wire              addr_retry_n,
  input  wire              addr_bus_busy_n_in,
  output reg               addr_bus_busy_n_out,
  output reg               addr_bus_busy_n_oe,
  input  wire              xfer_begin_n_in,
  output reg               xfer_begin_n_out,
  output reg               xfer_begin_n_oe,
  input  wire [ADDR_W-1:0] addr_in,
  output reg  [ADDR_W-1:0] addr_out,
  output reg               addr_oe,
  input  wire [3:0]        addr_byte_parity_in,
  output reg  [3:0]        addr_byte_parity_out,
  output reg  [TT_W-1:0]   transfer_type_code_out,
  output reg               data_bus_req,
  output reg               snoop_valid,
  output reg  [ADDR_W-1:0] snoop_addr,
  output reg  [TT_W-1:0]   snoop_type,
  input  wire [TT_W-1:0]   transfer_type_code_in,
  output reg               mach_check_event,
  output reg               checkstop_event
);
  reg  [1:0]        state_reg;
  reg  [1:0]        state_next;
  reg               grant_meta_reg;
  reg               grant_sync_reg;
  reg               ack_meta_reg;
  reg               ack_sync_reg;
  reg               retry_meta_reg;
  reg               retry_sync_reg;
  reg               busy_meta_reg;
  reg               busy_sync_reg;
  reg               ts_meta_reg;
  reg               ts_sync_reg;
  reg               pchk_meta_reg;
  reg               pchk_sync_reg;
  reg  [ADDR_W-1:0] a_meta_reg;
  reg  [ADDR_W-1:0] a_sync_reg;
  reg  [3:0]        p_meta_reg;
  reg  [3:0]        p_sync_reg;
  reg  [TT_W-1:0]   t_meta_reg;
  reg  [TT_W-1:0]   t_sync_reg;
  reg               ack_seen_reg;
  wire              grant_s;
  wire              ack_s;
  wire              retry_s;
  wire              busy_s;
  wire              ts_s;
  wire              pchk_s;
  wire              qual_grant;
  wire              take;
  wire [ADDR_W-1:0] lane_addr;
  wire [3:0]        out_par;
  wire [3:0]        unused_par;
  wire              snoop_perr;
  wire              unused_err;
  wire              snoop_hit;

  assign grant_s = ~grant_sync_reg;
  assign ack_s   = ~ack_sync_reg;
  assign retry_s = ~retry_sync_reg;
  assign busy_s  = ~busy_sync_reg;
  assign ts_s    = ~ts_sync_reg;
  assign pchk_s  = pchk_sync_reg;

  // all bus inputs cross two flops; tenure timing is thus relative to
  // the synchronised view, a latency trade for metastability safety.
  // control flops reset to the negated pin level, so no false start follows reset
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      grant_meta_reg <= 1'b1;
      grant_sync_reg <= 1'b1;
      ack_meta_reg   <= 1'b1;
      ack_sync_reg   <= 1'b1;
      retry_meta_reg <= 1'b1;
      retry_sync_reg <= 1'b1;
      busy_meta_reg  <= 1'b1;
      busy_sync_reg  <= 1'b1;
      ts_meta_reg    <= 1'b1;
      ts_sync_reg    <= 1'b1;
      pchk_meta_reg  <= 1'b0;
      pchk_sync_reg  <= 1'b0;
    end else begin
      grant_meta_reg <= bus_grant_n;
      grant_sync_reg <= grant_meta_reg;
      ack_meta_reg   <= addr_acknowledge_n;
      ack_sync_reg   <= ack_meta_reg;
      retry_meta_reg <= addr_retry_n;
      retry_sync_reg <= retry_meta_reg;
      busy_meta_reg  <= addr_bus_busy_n_in;
      busy_sync_reg  <= busy_meta_reg;
      ts_meta_reg    <= xfer_begin_n_in;
      ts_sync_reg    <= ts_meta_reg;
      pchk_meta_reg  <= parity_check_en;
      pchk_sync_reg  <= pchk_meta_reg;
    end
  end

  // snooped address, parity and type travel with the same two-flop delay
  // as the start strobe, so they line up in the synchronised start cycle
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      a_meta_reg <= {ADDR_W{1'b0}};
      a_sync_reg <= {ADDR_W{1'b0}};
      p_meta_reg <= 4'h0;
      p_sync_reg <= 4'h0;
      t_meta_reg <= {TT_W{1'b0}};
      t_sync_reg <= {TT_W{1'b0}};
    end else begin
      a_meta_reg <= addr_in;
      a_sync_reg <= a_meta_reg;
      p_meta_reg <= addr_byte_parity_in;
      p_sync_reg <= p_meta_reg;
      t_meta_reg <= transfer_type_code_in;
      t_sync_reg <= t_meta_reg;
    end
  end

  // qualification checked two cycles after acknowledge, once back in idle, or when idle bus
  assign qual_grant = grant_s & ~busy_s & ~retry_s;
  assign take       = (state_reg == `ATBI_ST_IDLE) & req_valid & qual_grant;
  assign req_ready  = take;

  // burst writes go out at the requested address unchanged; reads at the aligned critical word
  assign lane_addr = (req_burst & ~req_write) ? (req_addr & `ATBI_DW_MASK) :
                     req_addr;

  atbi_parity u_out_par (
    .addr    (lane_addr),
    .par_in  (4'h0),
    .par_gen (out_par),
    .par_err (unused_err)
  );

  atbi_parity u_snp_par (
    .addr    (a_sync_reg),
    .par_in  (p_sync_reg),
    .par_gen (unused_par),
    .par_err (snoop_perr)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ATBI_ST_IDLE: begin
        if (take)
          state_next = `ATBI_ST_START;
      end
      `ATBI_ST_START: begin
        if (ack_s)
          state_next = `ATBI_ST_FLOAT;
        else
          state_next = `ATBI_ST_WAIT;
      end
      `ATBI_ST_WAIT: begin
        if (ack_s)
          state_next = `ATBI_ST_FLOAT;
      end
      `ATBI_ST_FLOAT: begin
        state_next = `ATBI_ST_IDLE;
      end
      default: begin
        state_next = `ATBI_ST_IDLE;
      end
    endcase
  end

  // busy and start sequencing of our own tenure
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg           <= `ATBI_ST_IDLE;
      addr_bus_busy_n_out <= 1'b1;
      addr_bus_busy_n_oe  <= 1'b0;
      xfer_begin_n_out    <= 1'b1;
      xfer_begin_n_oe     <= 1'b0;
      data_bus_req        <= 1'b0;
      ack_seen_reg        <= 1'b0;
    end else begin
      state_reg    <= state_next;
      data_bus_req <= 1'b0;
      ack_seen_reg <= 1'b0;
      if (take) begin
        // busy, start and the data request appear with the address
        addr_bus_busy_n_out <= 1'b0;
        addr_bus_busy_n_oe  <= 1'b1;
        xfer_begin_n_out    <= 1'b0;
        xfer_begin_n_oe     <= 1'b1;
        data_bus_req        <= req_type[`ATBI_TT_DATA_BIT] !=
                               `ATBI_TT_ADDR_ONLY;
      end else begin
        if (state_reg == `ATBI_ST_START)
          xfer_begin_n_out <= 1'b1;
        if ((state_reg == `ATBI_ST_START || state_reg == `ATBI_ST_WAIT) && ack_s) begin
          // negate busy and float start together after acknowledge
          addr_bus_busy_n_out <= 1'b1;
          xfer_begin_n_out    <= 1'b1;
          xfer_begin_n_oe     <= 1'b0;
          ack_seen_reg        <= 1'b1;
        end
        // busy stops driving with the address, two cycles after acknowledge
        if (ack_seen_reg)
          addr_bus_busy_n_oe <= 1'b0;
      end
    end
  end

  // address, parity and type share one enable and one load point
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_out               <= {ADDR_W{1'b0}};
      addr_oe                <= 1'b0;
      addr_byte_parity_out   <= 4'h0;
      transfer_type_code_out <= {TT_W{1'b0}};
    end else begin
      if (take) begin
        addr_out               <= lane_addr;
        addr_oe                <= 1'b1;
        addr_byte_parity_out   <= out_par;
        transfer_type_code_out <= req_type;
      end else if (state_reg == `ATBI_ST_FLOAT) begin
        // loaded only on acceptance, so a burst never advances it
        addr_oe <= 1'b0;
      end
    end
  end

  // snoop sampling only in another master's start cycle; own start is not
  // snooped, and others start only while the bus is busy
  assign snoop_hit = ts_s & busy_s & ~xfer_begin_n_oe;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      snoop_valid <= 1'b0;
      snoop_addr  <= {ADDR_W{1'b0}};
      snoop_type  <= {TT_W{1'b0}};
    end else begin
      snoop_valid <= 1'b0;
      if (snoop_hit) begin
        snoop_valid <= 1'b1;
        snoop_addr  <= a_sync_reg;
        snoop_type  <= t_sync_reg;
      end
    end
  end

  // single-cycle events; the exception logic decides what they lead to
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mach_check_event <= 1'b0;
      checkstop_event  <= 1'b0;
    end else begin
      mach_check_event <= 1'b0;
      checkstop_event  <= 1'b0;
      if (snoop_hit) begin
        mach_check_event <= pchk_s & snoop_perr & mach_check_en;
        checkstop_event  <= pchk_s & snoop_perr & ~mach_check_en;
      end
    end
  end
endmodule

// ==== rtl/atbi_defs.vh ====
/*
  constants for the address-tenure bus interface: widths, encodings, states.
  assumes inclusion by atbi_addr_tenure.v and atbi_parity.v only.
*/
`ifndef ATBI_DEFS_VH
`define ATBI_DEFS_VH

`define ATBI_ADDR_W        32
`define ATBI_PAR_W         4
`define ATBI_TT_W          5
`define ATBI_TT_ADDR_ONLY  1'b0
`define ATBI_TT_DATA_BIT   3
`define ATBI_TT_FETCH_BIT  4
`define ATBI_DW_MASK       32'hfffffff8
`define ATBI_ST_IDLE       2'h0
`define ATBI_ST_START      2'h1
`define ATBI_ST_WAIT       2'h2
`define ATBI_ST_FLOAT      2'h3

`endif

// ==== rtl/atbi_parity.v ====
/*
  odd byte parity generator and checker for a 32-bit address.
  assumes byte 0 is addr[31:24], matching parity bit 0.
*/
`include "atbi_defs.vh"

module atbi_parity (
  addr,
  par_in,
  par_gen,
  par_err
);
  input  wire [`ATBI_ADDR_W-1:0] addr;
  input  wire [`ATBI_PAR_W-1:0]  par_in;
  output wire [`ATBI_PAR_W-1:0]  par_gen;
  output wire                    par_err;

  // bit 0 covers the first (most significant) byte
  assign par_gen[0] = ~^addr[31:24];
  assign par_gen[1] = ~^addr[23:16];
  assign par_gen[2] = ~^addr[15:8];
  assign par_gen[3] = ~^addr[7:0];
  // any nine-bit group with even ones count is an error
  assign par_err = |(par_gen ^ par_in);
endmodule

// ==== testbench/atbi_bus_model.sv ====
/*
  far side: arbiter, memory controller and one other snooped master.
  assumes one clock; controls pull up, an undriven address bus keeps changing.
*/
module atbi_bus_model (
  input  logic        sys_clk,
  input  logic        arst_n,
  input  logic        addr_bus_busy_n_out,
  input  logic        addr_bus_busy_n_oe,
  input  logic        xfer_begin_n_out,
  input  logic        xfer_begin_n_oe,
  input  logic [31:0] addr_out,
  input  logic        addr_oe,
  input  logic [3:0]  addr_byte_parity_out,
  input  logic [4:0]  transfer_type_code_out,
  input  logic [7:0]  ack_wait,
  input  logic        snoop_go,
  input  logic [31:0] snoop_a,
  input  logic        snoop_bad,
  input  logic        retry_hold,
  output logic        bus_grant_n,
  output logic        addr_acknowledge_n,
  output logic        addr_retry_n,
  output logic        addr_bus_busy_n_in,
  output logic        xfer_begin_n_in,
  output logic [31:0] addr_in,
  output logic [3:0]  addr_byte_parity_in,
  output logic [4:0]  transfer_type_code_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cnt;
  logic        m_busy;
  logic        m_start;
  logic [40:0] last_v;
  wire  [3:0]  good_p = {~^snoop_a[7:0], ~^snoop_a[15:8], ~^snoop_a[23:16], ~^snoop_a[31:24]};
  wire  [40:0] bus_v  = addr_oe ? {addr_out, addr_byte_parity_out, transfer_type_code_out}
                      : m_start ? {snoop_a, good_p ^ {3'h0, snoop_bad}, 5'h0a} : ~last_v;
  assign {addr_in, addr_byte_parity_in, transfer_type_code_in} = bus_v;
  assign addr_bus_busy_n_in = addr_bus_busy_n_oe ? addr_bus_busy_n_out : !m_busy;
  assign xfer_begin_n_in    = xfer_begin_n_oe ? xfer_begin_n_out : !m_start;
  // grant withheld while the other master owns the bus; its own start does not wait for our busy to negate
  assign bus_grant_n        = m_busy;
  assign addr_retry_n       = !retry_hold;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      m_busy <= 1'b0;
      m_start <= 1'b0;
      last_v <= '0;
      addr_acknowledge_n <= 1'b1;
    end else begin
      last_v <= bus_v;
      addr_acknowledge_n <= 1'b1;
      m_start <= snoop_go && !m_busy;
      m_busy <= (snoop_go && !m_busy) || m_start;
      if (xfer_begin_n_oe && !xfer_begin_n_out) begin
        cnt <= ack_wait;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        addr_acknowledge_n <= (cnt != 8'h01);
      end
    end
  end
endmodule

// ==== testbench/atbi_tenure_props.sv ====
/*
  checker for atbi_addr_tenure: start strobe, address and parity drive, events.
  assumes a bind onto the top module and stable enable levels around snoops.
*/
module atbi_tenure_props #(parameter ADDR_W = 32) (
  input logic              sys_clk,
  input logic              arst_n,
  input logic              req_ready,
  input logic              addr_bus_busy_n_out,
  input logic              xfer_begin_n_out,
  input logic              xfer_begin_n_oe,
  input logic [ADDR_W-1:0] addr_out,
  input logic              addr_oe,
  input logic [3:0]        addr_byte_parity_out,
  input logic [4:0]        transfer_type_code_out,
  input logic              data_bus_req,
  input logic              parity_check_en,
  input logic              mach_check_en,
  input logic              mach_check_event,
  input logic              checkstop_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire                     start_on = xfer_begin_n_oe && !xfer_begin_n_out;
  wire [3:0]               p        = addr_byte_parity_out;
  sequence s_begin;
    start_on && !addr_bus_busy_n_out && addr_oe;
  endsequence
  chk_grant_start: assert property (req_ready |=> s_begin ##1 !start_on)
    else $error("start, busy and address not driven after acceptance");
  chk_start_once: assert property (start_on |=> !start_on [*3])
    else $error("start strobe wider than one cycle");
  chk_start_busy: assert property (start_on |-> !addr_bus_busy_n_out && addr_oe)
    else $error("start without busy and address");
  chk_start_float: assert property ($rose(addr_bus_busy_n_out) |-> !xfer_begin_n_oe)
    else $error("start still driven when busy negates");
  chk_addr_float: assert property ($rose(addr_bus_busy_n_out) |-> addr_oe ##1 !addr_oe)
    else $error("address not floated one cycle after busy negation");
  chk_addr_hold: assert property (addr_oe && $past(addr_oe) |->
    $stable(addr_out) && $stable(addr_byte_parity_out))
    else $error("address or parity changed during tenure");
  chk_parity_odd: assert property (addr_oe |-> ^{addr_out[31:24], p[0]} &&
    ^{addr_out[23:16], p[1]} && ^{addr_out[15:8], p[2]} && ^{addr_out[7:0], p[3]})
    else $error("address parity not odd");
  chk_data_req: assert property (data_bus_req == (start_on && transfer_type_code_out[3]))
    else $error("data bus request does not follow start and type");
  chk_event_kind: assert property (mach_check_event |-> mach_check_en && parity_check_en)
    else $error("machine check event without enables");
  chk_stop_kind: assert property (checkstop_event |-> !mach_check_en && parity_check_en)
    else $error("checkstop event with machine check enabled");
endmodule

// ==== testbench/test_atbi_addr_tenure.sv ====
/*
  testbench for atbi_addr_tenure: master tenures of nine types, bursts, snoops.
  assumes atbi_bus_model on the far side and the checker bound below.
*/
module test_atbi_addr_tenure;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, arst_n = 0, req_valid = 0, req_burst = 0, req_write = 0;
  logic parity_check_en = 1, mach_check_en = 1, snoop_go = 0, snoop_bad = 0;
  logic retry_hold = 0;
  logic [31:0] req_addr = 0, snoop_a = 0;
  logic [4:0] req_type = 0;
  logic [7:0] ack_wait = 8'h02;
  logic req_ready, addr_bus_busy_n_out, addr_bus_busy_n_oe, xfer_begin_n_out, xfer_begin_n_oe;
  logic addr_oe, data_bus_req, snoop_valid, mach_check_event, checkstop_event;
  logic bus_grant_n, addr_acknowledge_n, addr_retry_n, addr_bus_busy_n_in, xfer_begin_n_in;
  logic [31:0] addr_out, addr_in, snoop_addr;
  logic [3:0] addr_byte_parity_out, addr_byte_parity_in;
  logic [4:0] transfer_type_code_out, transfer_type_code_in, snoop_type;
  int n_fail = 0, comparisons = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  atbi_addr_tenure dut (.*);
  atbi_bus_model far (.*);
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tenure(input logic [31:0] a, exp_a, input logic [4:0] t, input logic b, w);
    int k;
    req_addr <= a;
    req_type <= t;
    req_burst <= b;
    req_write <= w;
    req_valid <= 1'b1;
    k = 0;
    do @(posedge sys_clk); while (req_ready !== 1'b1 && ++k < 40);
    req_valid <= 1'b0;
    k = 0;
    do @(posedge sys_clk); while (!(xfer_begin_n_oe === 1'b1 && xfer_begin_n_out === 1'b0) && ++k < 9);
    check("address", addr_out, exp_a);
    check("parity", addr_byte_parity_out,
      {~^exp_a[7:0], ~^exp_a[15:8], ~^exp_a[23:16], ~^exp_a[31:24]});
    check("type", transfer_type_code_out, t);
    check("data request", data_bus_req, t[3]);
    k = 0;
    do @(posedge sys_clk); while (addr_oe !== 1'b0 && ++k < 40);
    $display("tenure type %h done", t);
  endtask
  task automatic snoop(input logic [31:0] a, input logic bad, exp_mc, exp_cs);
    logic mc, cs, sv;
    logic [31:0] sa;
    logic [4:0] st;
    st = 0;
    mc = 0;
    cs = 0;
    sv = 0;
    sa = 0;
    snoop_a <= a;
    snoop_bad <= bad;
    snoop_go <= 1'b1;
    @(posedge sys_clk);
    snoop_go <= 1'b0;
    repeat (12) begin
      @(posedge sys_clk);
      mc |= mach_check_event;
      cs |= checkstop_event;
      if (snoop_valid === 1'b1) begin
        sa = snoop_addr;
        st = snoop_type;
      end
      sv |= snoop_valid;
    end
    check("snoop seen", sv, 1'b1);
    check("snoop address", sa, a);
    check("snoop type", st, 5'h0a);
    check("machine check", mc, exp_mc);
    check("checkstop", cs, exp_cs);
    $display("snoop %h done", a);
  endtask
  task automatic blocked(input logic [31:0] a);
    logic seen;
    seen = 0;
    retry_hold <= 1'b1;
    req_addr <= a;
    req_type <= 5'h0a;
    req_burst <= 1'b0;
    req_write <= 1'b0;
    repeat (3) @(posedge sys_clk);
    req_valid <= 1'b1;
    repeat (6) begin
      @(posedge sys_clk);
      seen |= req_ready;
    end
    check("grant under retry", seen, 1'b0);
    retry_hold <= 1'b0;
    $display("retry hold done");
    tenure(a, a, 5'h0a, 1'b0, 1'b0);
  endtask
  // address-only codes first, then the data-moving ones
  logic [4:0] codes [9] = '{5'h00, 5'h04, 5'h02, 5'h06, 5'h01, 5'h08, 5'h0c, 5'h0a, 5'h0e};
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (codes[i]) tenure(32'h1234_5677 + i, 32'h1234_5677 + i, codes[i], 1'b0, 1'b0);
    ack_wait <= 8'h06;
    tenure(32'h8000_001c, 32'h8000_0018, 5'h0e, 1'b1, 1'b0);
    tenure(32'h4000_0024, 32'h4000_0024, 5'h0c, 1'b1, 1'b1);
    blocked(32'h2468_ace1);
    snoop(32'h0bad_cafe, 1'b0, 1'b0, 1'b0);
    snoop(32'h0000_00ff, 1'b1, 1'b1, 1'b0);
    mach_check_en <= 1'b0;
    snoop(32'h5555_aaaa, 1'b1, 1'b0, 1'b1);
    parity_check_en <= 1'b0;
    snoop(32'h1357_9bdf, 1'b1, 1'b0, 1'b0);
    conclude();
  end
endmodule
bind atbi_addr_tenure atbi_tenure_props #(.ADDR_W(ADDR_W)) chk (.*);
